/* File: design/mfpr_pkg.sv */
/*
  Constants for the multifunction pin router: register offsets, reset
  values, function codes and control signal indices.
  Assumes nothing of its surroundings beyond a SystemVerilog compiler.
*/
`default_nettype none
package mfpr_pkg;
  // Pin count and configuration register layout.
  localparam int          NUM_PINS        = 8;
  localparam logic [11:0] PIN_CFG_BASE    = 12'h0200;
  localparam logic [11:0] PIN_CFG_LAST    = 12'h0207;
  localparam int          DIR_BIT         = 7;
  localparam logic [7:0]  PIN_CFG_RESET   = 8'h00;

  // Output (monitor) function codes.
  localparam logic [6:0] OUT_FAULT_FIRST  = 7'h22;
  localparam logic [6:0] OUT_FAULT_LAST   = 7'h27;
  localparam logic [6:0] OUT_VALID_FIRST  = 7'h30;
  localparam logic [6:0] OUT_VALID_LAST   = 7'h37;
  localparam logic [6:0] OUT_ACTREF_FIRST = 7'h40;
  localparam logic [6:0] OUT_ACTREF_LAST  = 7'h47;
  localparam logic [6:0] OUT_SYNC_PULSE   = 7'h50;

  // Input (control) function codes.
  localparam logic [6:0] IN_IO_UPDATE     = 7'h01;
  localparam logic [6:0] IN_POWER_DOWN    = 7'h02;
  localparam logic [6:0] IN_WDOG_RESET    = 7'h03;
  localparam logic [6:0] IN_IRQ_RESET     = 7'h04;
  localparam logic [6:0] IN_TW_RESET      = 7'h05;
  localparam logic [6:0] IN_HOLDOVER      = 7'h10;
  localparam logic [6:0] IN_FREE_RUN      = 7'h11;
  localparam logic [6:0] IN_PH_RESET      = 7'h12;
  localparam logic [6:0] IN_PH_INC        = 7'h13;
  localparam logic [6:0] IN_PH_DEC        = 7'h14;
  localparam logic [6:0] IN_OVR_FIRST     = 7'h20;
  localparam logic [6:0] IN_OVR_LAST      = 7'h27;
  localparam logic [6:0] IN_VTO_FIRST     = 7'h30;
  localparam logic [6:0] IN_VTO_LAST      = 7'h37;
  localparam logic [6:0] IN_EN_FIRST      = 7'h40;
  localparam logic [6:0] IN_EN_LAST       = 7'h43;
  localparam logic [6:0] IN_EN_ALL        = 7'h44;
  localparam logic [6:0] IN_SYNC_CMD      = 7'h45;

  // Status bit positions within each reference status byte.
  localparam int REF_FAULT_BIT = 2;
  localparam int REF_VALID_BIT = 3;

  // Control signal indices on the flat control vector.
  localparam int CTL_IO_UPDATE  = 0;
  localparam int CTL_POWER_DOWN = 1;
  localparam int CTL_WDOG_RESET = 2;
  localparam int CTL_IRQ_RESET  = 3;
  localparam int CTL_TW_RESET   = 4;
  localparam int CTL_HOLDOVER   = 5;
  localparam int CTL_FREE_RUN   = 6;
  localparam int CTL_PH_RESET   = 7;
  localparam int CTL_PH_INC     = 8;
  localparam int CTL_PH_DEC     = 9;
  localparam int CTL_OVR_BASE   = 10;
  localparam int CTL_VTO_BASE   = 18;
  localparam int CTL_EN_BASE    = 26;
  localparam int CTL_SYNC_CMD   = 30;
  localparam int NUM_CTL        = 31;

  // Strap capture sequencer states.
  typedef enum logic [1:0] {
    STRAP_WAIT,
    STRAP_HOLD,
    STRAP_DONE
  } mfpr_strap_state_type;
endpackage
`default_nettype wire

/* File: design/mfpr_ctl_if.sv */
/*
  Interface carrying the per-pin routed control requests from the
  router top to the pin arbiter, and the resolved levels back.
  Assumes one clock domain; it carries plain combinational levels.
*/
`default_nettype none
interface mfpr_ctl_if;
  import mfpr_pkg::*;
  // Per-pin decoded control request, one row per pin.
  logic [NUM_CTL-1:0] req [NUM_PINS];
  // Resolved control level after priority selection.
  logic [NUM_CTL-1:0] ctl;
  // Which control signals have any pin source at all.
  logic [NUM_CTL-1:0] owned;

  modport arb (input req, output ctl, output owned);
  modport top (output req, input ctl, input owned);
endinterface
`default_nettype wire

/* File: design/mfpr_arbiter.sv */
/*
  Priority arbiter: for each control signal, picks the lowest numbered
  pin that targets it and passes that pin's level through.
  Assumes per-pin requests hold 1 in "claim" and level in "req".
*/
`default_nettype none
module mfpr_arbiter
  import mfpr_pkg::*;
(
  // Per-pin claims on each control signal.
  input  wire logic [NUM_CTL-1:0] claim [NUM_PINS],
  // Request and result carrier.
  mfpr_ctl_if.arb                 bus
);
  // Walk from the highest pin down so the lowest pin wins last.
  always_comb begin
    bus.ctl   = '0;
    bus.owned = '0;
    for (int p = NUM_PINS - 1; p >= 0; p--) begin
      for (int c = 0; c < NUM_CTL; c++) begin
        if (claim[p][c]) begin
          bus.ctl[c]   = bus.req[p][c];
          bus.owned[c] = 1'b1;
        end
      end
    end
  end
endmodule
`default_nettype wire

/* File: design/mfpr_router.sv */
/*
  Multifunction pin router top: eight configuration registers on the
  documented register port, direction and function selection per pin,
  status monitoring outputs, control inputs with priority, and strap
  capture after reset.
  Assumes pins are asynchronous to core_clk and that the register port
  and the internal status and control signals are on core_clk.
*/
`default_nettype none
module mfpr_router
  import mfpr_pkg::*;
(
  // Clock and reset.
  input  wire logic        core_clk,
  input  wire logic        arst_n,
  // Register port.
  input  wire logic [11:0] reg_addr,
  input  wire logic        reg_wr,
  input  wire logic [7:0]  reg_wdata,
  output var  logic [7:0]  reg_rdata,
  // Multifunction pins, three signals each.
  input  wire logic [7:0]  mf_pin_in,
  output var  logic [7:0]  mf_pin_out,
  output var  logic [7:0]  mf_pin_oe,
  // Internal status sources.
  input  wire logic [7:0]  ref_status [NUM_PINS],
  input  wire logic [2:0]  active_ref,
  input  wire logic        sync_pulse_status,
  // Register-side control bits.
  input  wire logic [NUM_CTL-1:0] reg_ctl,
  // Combined control signals to the core.
  output var  logic [NUM_CTL-1:0] ctl_out,
  // Pin levels captured after reset for strapping.
  output var  logic [7:0]  strap_pins,
  output var  logic        strap_valid
);
  // Configuration registers, one per pin.
  logic [7:0] cfg_q [NUM_PINS];
  // Two stage synchroniser for the pin inputs.
  logic [7:0] pin_meta_q;
  logic [7:0] pin_sync_q;
  // Per pin claim of each control signal.
  logic [NUM_CTL-1:0] claim [NUM_PINS];
  // Status bit chosen by each output pin.
  logic [7:0] mon_d;
  // Strap capture sequencer.
  mfpr_strap_state_type strap_state_q;
  logic [7:0]           strap_q;
  logic                 strap_wait_q; // First edge after release seen.

  // Carrier between this module and the arbiter.
  mfpr_ctl_if ctl_bus ();

  // Address decode for the register port.
  wire        addr_hit = (reg_addr >= PIN_CFG_BASE) &&
                         (reg_addr <= PIN_CFG_LAST);
  wire [2:0]  addr_idx = reg_addr[2:0];

  // Function code is in range [first, last].
  function automatic logic in_range(input logic [6:0] code,
                                    input logic [6:0] first,
                                    input logic [6:0] last);
    in_range = (code >= first) && (code <= last);
  endfunction

  // Decode one input function code into a claim vector.
  function automatic logic [NUM_CTL-1:0] decode_in(input logic [6:0] c);
    logic [NUM_CTL-1:0] v;
    logic [2:0]         off;
    v   = '0;
    off = c[2:0];
    // Codes not matched below leave v clear, so they do nothing.
    case (c)
      IN_IO_UPDATE:  v[CTL_IO_UPDATE]  = 1'b1;
      IN_POWER_DOWN: v[CTL_POWER_DOWN] = 1'b1;
      IN_WDOG_RESET: v[CTL_WDOG_RESET] = 1'b1;
      IN_IRQ_RESET:  v[CTL_IRQ_RESET]  = 1'b1;
      IN_TW_RESET:   v[CTL_TW_RESET]   = 1'b1;
      IN_HOLDOVER:   v[CTL_HOLDOVER]   = 1'b1;
      IN_FREE_RUN:   v[CTL_FREE_RUN]   = 1'b1;
      IN_PH_RESET:   v[CTL_PH_RESET]   = 1'b1;
      IN_PH_INC:     v[CTL_PH_INC]     = 1'b1;
      IN_PH_DEC:     v[CTL_PH_DEC]     = 1'b1;
      IN_EN_ALL:     v[CTL_EN_BASE+:4] = 4'hF;
      IN_SYNC_CMD:   v[CTL_SYNC_CMD]   = 1'b1;
      default: begin
        if (in_range(c, IN_OVR_FIRST, IN_OVR_LAST)) begin
          v[CTL_OVR_BASE + int'(off)] = 1'b1;
        end else if (in_range(c, IN_VTO_FIRST, IN_VTO_LAST)) begin
          v[CTL_VTO_BASE + int'(off)] = 1'b1;
        end else if (in_range(c, IN_EN_FIRST, IN_EN_LAST)) begin
          v[CTL_EN_BASE + int'(off[1:0])] = 1'b1;
        end
        // Code 0 and every gap stay unconnected.
      end
    endcase
    decode_in = v;
  endfunction

  // Select the status bit an output pin shows.
  function automatic logic decode_out(input logic [6:0] c,
                                      input logic [7:0] rs [NUM_PINS],
                                      input logic [2:0] act,
                                      input logic       syncp);
    logic [2:0] off;
    off = c[2:0];
    decode_out = 1'b0;
    if (in_range(c, OUT_FAULT_FIRST, OUT_FAULT_LAST)) begin
      // Code 34 maps to reference B, index 2.
      decode_out = rs[off][REF_FAULT_BIT];
    end else if (in_range(c, OUT_VALID_FIRST, OUT_VALID_LAST)) begin
      decode_out = rs[off][REF_VALID_BIT];
    end else if (in_range(c, OUT_ACTREF_FIRST, OUT_ACTREF_LAST)) begin
      decode_out = (act == off);
    end else if (c == OUT_SYNC_PULSE) begin
      decode_out = syncp;
    end
    // Codes 81 to 127 and other gaps read as low.
  endfunction

  // Configuration register writes; reads are below.
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      for (int p = 0; p < NUM_PINS; p++) begin
        cfg_q[p] <= PIN_CFG_RESET;
      end
    end else if (reg_wr && addr_hit) begin
      // Pin functions follow only software after reset.
      cfg_q[addr_idx] <= reg_wdata;
    end
  end

  // Readback; unmapped addresses return zero.
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      reg_rdata <= '0;
    end else begin
      reg_rdata <= addr_hit ? cfg_q[addr_idx] : 8'h00;
    end
  end

  // Pins are asynchronous, so they pass two flops first.
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      pin_meta_q <= '0;
      pin_sync_q <= '0;
    end else begin
      pin_meta_q <= mf_pin_in;
      pin_sync_q <= pin_meta_q;
    end
  end

  // Per pin decode of claims, requests and monitored status.
  always_comb begin
    for (int p = 0; p < NUM_PINS; p++) begin
      if (cfg_q[p][DIR_BIT]) begin
        claim[p]       = '0; // Outputs claim no control.
        ctl_bus.req[p] = '0;
        mon_d[p]       = decode_out(cfg_q[p][6:0], ref_status,
                                    active_ref, sync_pulse_status);
      end else begin
        claim[p]       = decode_in(cfg_q[p][6:0]);
        ctl_bus.req[p] = {NUM_CTL{pin_sync_q[p]}};
        mon_d[p]       = 1'b0;
      end
    end
  end

  // Priority selection across pins.
  mfpr_arbiter u_arb (
    .claim (claim),
    .bus   (ctl_bus.arb)
  );

  // Pin or register bit may trigger; both feed one signal.
  assign ctl_out = reg_ctl | (ctl_bus.ctl & ctl_bus.owned);

  // Output pins are registered to avoid glitches from the decode.
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      mf_pin_out <= '0;
      mf_pin_oe  <= '0;
    end else begin
      mf_pin_out <= mon_d;
      for (int p = 0; p < NUM_PINS; p++) begin
        mf_pin_oe[p] <= cfg_q[p][DIR_BIT];
      end
    end
  end

  // Strap capture: wait for synchroniser to fill, then latch once.
  // The levels are caught by the third clock edge after release, never by reset.
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      strap_state_q <= STRAP_WAIT;
      strap_q       <= '0;
      strap_wait_q  <= 1'b0;
    end else begin
      case (strap_state_q)
        STRAP_WAIT: begin
          // The second stage holds reset zeros until the second edge,
          // so two edges pass before the pins are worth latching.
          strap_wait_q <= 1'b1;
          if (strap_wait_q) begin
            strap_state_q <= STRAP_HOLD;
          end
        end
        STRAP_HOLD: begin
          strap_q       <= pin_sync_q;
          strap_state_q <= STRAP_DONE;
        end
        STRAP_DONE: strap_state_q <= STRAP_DONE;
        default:    strap_state_q <= STRAP_WAIT;
      endcase
    end
  end

  assign strap_pins  = strap_q;
  assign strap_valid = (strap_state_q == STRAP_DONE);
endmodule
`default_nettype wire

/* File: tb/mfpr_router_checker.sv */
/* Port checker for the multifunction pin router.
   Assumes it is bound to mfpr_router and sees only its ports. */
`default_nettype none
module mfpr_router_checker
  import mfpr_pkg::*;
(
  // Clock, reset and register writes.
  input wire logic                core_clk,
  input wire logic                arst_n,
  input wire logic [11:0]         reg_addr,
  input wire logic                reg_wr,
  input wire logic [7:0]          reg_wdata,
  // Pins, status and control.
  input wire logic [7:0]          mf_pin_in,
  input wire logic [7:0]          mf_pin_out,
  input wire logic [7:0]          mf_pin_oe,
  input wire logic [7:0]          ref_status [NUM_PINS],
  input wire logic [2:0]          active_ref,
  input wire logic                sync_pulse_status,
  input wire logic [NUM_CTL-1:0]  reg_ctl,
  input wire logic [NUM_CTL-1:0]  ctl_out,
  input wire logic [7:0]          strap_pins,
  input wire logic                strap_valid
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] cfg0_q;  // Mirror of pin 0 config.
  logic [7:0] cfg0_p;  // The mirror one edge ago.
  // Selected sources, so $past sees the index of its own cycle.
  wire logic flt = ref_status[cfg0_q[2:0]][REF_FAULT_BIT];
  wire logic vld = ref_status[cfg0_q[2:0]][REF_VALID_BIT];
  wire logic act = active_ref == cfg0_q[2:0];
  // The mirror loads on the same edge as the design's register.
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      cfg0_q <= 8'h00;
      cfg0_p <= 8'h00;
    end else begin
      if (reg_wr && reg_addr == PIN_CFG_BASE) cfg0_q <= reg_wdata;
      cfg0_p <= cfg0_q;
    end
  end
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!arst_n);
  chk_oe_dir_bit: assert property (mf_pin_oe[0] == cfg0_p[7])
    else $error("pin 0 enable differs from its direction bit");
  chk_fault_flag: assert property (cfg0_p inside {[8'hA2:8'hA7]}
    |-> mf_pin_out[0] == $past(flt)) else $error("fault flag wrong");
  chk_valid_flag: assert property (cfg0_p inside {[8'hB0:8'hB7]}
    |-> mf_pin_out[0] == $past(vld)) else $error("valid flag wrong");
  chk_active_ref: assert property (cfg0_p inside {[8'hC0:8'hC7]}
    |-> mf_pin_out[0] == $past(act)) else $error("active flag wrong");
  chk_sync_pulse: assert property (cfg0_p == 8'hD0
    |-> mf_pin_out[0] == $past(sync_pulse_status))
    else $error("sync pulse output wrong");
  chk_unused_low: assert property (cfg0_p[7] && cfg0_p[6:0] > 7'h50
    |-> !mf_pin_out[0]) else $error("unused output code drives high");
  chk_pin_strobe: assert property (cfg0_p == 8'h01 && cfg0_q == 8'h01
    |-> ctl_out[0] == ($past(mf_pin_in[0], 2) | reg_ctl[0]))
    else $error("pin 0 strobe does not reach control 0");
  chk_reg_or_pin: assert property ((ctl_out & reg_ctl) == reg_ctl)
    else $error("register control bit lost");
  chk_strap_hold: assert property (strap_valid
    |=> strap_valid && $stable(strap_pins)) else $error("strap changed");
endmodule
bind mfpr_router mfpr_router_checker i_mfpr_router_checker (
  .core_clk, .arst_n, .reg_addr, .reg_wr, .reg_wdata, .mf_pin_in,
  .mf_pin_out, .mf_pin_oe, .ref_status, .active_ref, .sync_pulse_status,
  .reg_ctl, .ctl_out, .strap_pins, .strap_valid);
`default_nettype wire

/* File: tb/mfpr_board.sv */
/* Board model on the far side of the eight pins.
   Assumes the bench sets the wanted levels off the clock edge. */
`default_nettype none
module mfpr_board (
  // Levels the board puts on pins the router does not drive.
  input  wire logic [7:0] drv_lvl,
  // Router drive of the shared pins.
  input  wire logic [7:0] pin_out,
  input  wire logic [7:0] pin_oe,
  // Resolved pin levels.
  output var  logic [7:0] pin_lvl
);
  timeunit 1ns;
  timeprecision 1ns;
  // An output pin shows the router's drive; the board never fights it.
  assign pin_lvl = (pin_oe & pin_out) | (~pin_oe & drv_lvl);
endmodule
`default_nettype wire

/* File: tb/tb.sv */
/* Bench for the pin router: straps, registers, monitor and control codes.
   Assumes the router, its checker and the board model are compiled. */
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic        core_clk = 1'b0;
  logic        arst_n = 1'b0;
  logic [11:0] reg_addr = 12'h000;
  logic        reg_wr = 1'b0;
  logic [7:0]  reg_wdata = 8'h00, drv = 8'h00;
  logic [7:0]  reg_rdata, mf_pin_in, mf_pin_out, mf_pin_oe, strap_pins;
  logic [7:0]  rs [8] = '{default: 8'h00};
  logic [2:0]  active_ref = 3'h0;
  logic        sync_ps = 1'b0;
  logic        strap_valid;
  logic [30:0] reg_ctl = 31'h0, ctl_out;
  int          n_mismatch = 0;
  int          comparisons = 0;
  always #20 core_clk = ~core_clk;
  mfpr_router i_mfpr_router (.core_clk, .arst_n, .reg_addr, .reg_wr,
    .reg_wdata, .reg_rdata, .mf_pin_in, .mf_pin_out, .mf_pin_oe,
    .ref_status(rs), .active_ref, .sync_pulse_status(sync_ps), .reg_ctl,
    .ctl_out, .strap_pins, .strap_valid);
  mfpr_board i_mfpr_board (.drv_lvl(drv), .pin_out(mf_pin_out),
    .pin_oe(mf_pin_oe), .pin_lvl(mf_pin_in));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_mismatch++;
      $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // One write, strobe held for exactly one edge.
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    @(negedge core_clk);
    reg_addr = a;
    reg_wr = 1'b1;
    reg_wdata = d;
    @(negedge core_clk);
    reg_wr = 1'b0;
  endtask
  // Pin 0 as monitor output with the expected level.
  task automatic mon(input logic [7:0] cfg, input logic e);
    wr(12'h200, cfg);
    repeat (2) @(negedge core_clk);
    chk({mf_pin_oe[0], mf_pin_out[0]}, {1'b1, e});
  endtask
  function automatic logic [31:0] ctl_exp(input int c);
    if (c == 68) return 32'h3C00_0000;
    if (c == 69) return 32'h4000_0000;
    if (c inside {[1:5]}) return 32'h1 << (c - 1);
    if (c inside {[16:20]}) return 32'h1 << (c - 11);
    if (c inside {[32:39]}) return 32'h1 << (c - 22);
    if (c inside {[48:55]}) return 32'h1 << (c - 30);
    if (c inside {[64:67]}) return 32'h1 << (c - 38);
    return 32'h0;
  endfunction
  task automatic t_strap();
    drv = 8'hA5;
    arst_n = 1'b0;
    repeat (12) @(negedge core_clk);
    arst_n = 1'b1;
    repeat (5) @(negedge core_clk);
    chk({strap_valid, strap_pins}, 9'h1A5);
    drv = 8'h5A;
    repeat (5) @(negedge core_clk);
    chk({strap_valid, strap_pins, mf_pin_oe}, 17'h1_A500);
    $display("t_strap done");
  endtask
  task automatic t_regs();
    for (int i = 0; i < 8; i++) wr(12'h200 + 12'(i), 8'h10 + 8'(i));
    for (int i = 0; i <= 8; i++) begin
      reg_addr = 12'h200 + 12'(i);
      repeat (2) @(negedge core_clk);
      chk(reg_rdata, i < 8 ? 8'h10 + 8'(i) : 8'h00);
    end
    $display("t_regs done");
  endtask
  task automatic t_out();
    for (int k = 0; k < 8; k++) begin
      // Fault alone on the chosen reference, valid alone elsewhere,
      // so a swapped flag bit or a wrong index shows up.
      foreach (rs[j]) rs[j] = (j == k) ? 8'h04 : 8'h08;
      active_ref = 3'(k);
      if (k >= 2) mon(8'hA0 + 8'(k), 1'b1);
      mon(8'hB0 + 8'(k), 1'b0);
      mon(8'hB7 - 8'(k), 1'b1);
      mon(8'hC0 + 8'(k), 1'b1);
      mon(8'hC7 - 8'(k), 1'b0);
    end
    mon(8'hA6, 1'b0);
    mon(8'hB8, 1'b0);
    sync_ps = 1'b1;
    mon(8'hD0, 1'b1);
    mon(8'hD1, 1'b0);
    wr(12'h200, 8'h00);
    $display("t_out done");
  endtask
  task automatic t_in();
    drv = 8'h02;
    for (int c = 0; c < 128; c++) begin
      wr(12'h201, 8'(c));
      repeat (3) @(negedge core_clk);
      chk({mf_pin_oe[1], ctl_out}, ctl_exp(c));
    end  // Loop above also
    wr(12'h200, 8'h01);
    wr(12'h203, 8'h01);
    drv = 8'h08;
    repeat (3) @(negedge core_clk);
    chk(ctl_out[0], 1'b0);
    drv = 8'h01;
    repeat (3) @(negedge core_clk);
    chk(ctl_out[0], 1'b1);
    drv = 8'h00;
    reg_ctl = 31'h4000_0000;
    repeat (3) @(negedge core_clk);
    chk({1'b0, ctl_out}, 32'h4000_0000);
    reg_ctl = 31'h0;
    $display("t_in done");
  endtask
  task automatic results();
    $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  initial begin
    t_strap();
    t_regs();
    t_out();
    t_in();
    results();
  end
  // The whole run needs well under 3000 cycles.
  initial begin
    #400_000;
    n_mismatch++;
    results();
  end
endmodule
`default_nettype wire
